// file: bench/tb_limit_threshold_bank.sv
/*
  Self-checking testbench for the limit threshold bank top module.
  Assumes one 25 MHz clock, hready looped back from hreadyout, and
  a single bus master in this bench issuing single word transfers.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_limit_threshold_bank;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk;
  logic rst_n;
  logic ce;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [lmtb_pkg::N_CH-1:0][7:0] meas;
  logic [lmtb_pkg::N_CH-1:0] over;
  logic [lmtb_pkg::N_CH-1:0] under;
  logic ch2_analog;
  logic [31:0] rd;
  logic [7:0] v;
  int failures;
  int num_checks;

  // Device under test
  lmtb_top dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_meas(meas), .o_over(over), .o_under(under),
    .o_ch2_analog(ch2_analog)
  );

  // Free-running clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One single word transfer; waits for hready in both phases, watchdog ends a hang
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
    output logic [31:0] data);
    hsel <= 1'b1;
    htrans <= lmtb_pkg::HTRANS_NONSEQ;
    haddr <= {22'h000000, idx, 2'h0};
    hwrite <= wr;
    hsize <= lmtb_pkg::HSIZE_WORD;
    do
    begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do
    begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    data = hrdata;
  endtask

  // Register write and read
  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, idx, wd, dummy);
  endtask

  task automatic rd_reg(input logic [7:0] idx, output logic [31:0] data);
    bus(1'b0, idx, 32'h00000000, data);
  endtask

  // Let a new measurement reach the flags
  task automatic settle();
    repeat (2) @(posedge clk);
  endtask

  // Counts, verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Power-on value of each limit index
  function automatic logic [7:0] por_val(input logic [7:0] idx);
    if (idx == 8'h47 || (idx >= 8'h50 && idx <= 8'h57))
      return 8'hFF;
    if (idx == 8'h48 || idx == 8'h49)
      return 8'h80;
    return 8'h00;
  endfunction

  // Watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    failures = 0;
    num_checks = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    meas = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // Power-on values of the whole bank
    for (int i = 32'h47; i <= 32'h5C; i++)
    begin
      rd_reg(8'(i), rd);
      chk($sformatf("por %h", i), rd, {24'h000000, por_val(8'(i))});
    end
    // Distinct values everywhere, upper bus bits dirty, then read all back
    for (int i = 32'h47; i <= 32'h5C; i++)
      wr_reg(8'(i), {24'hDEAD5A, 8'(i) ^ 8'hA5});
    for (int i = 32'h47; i <= 32'h5C; i++)
    begin
      v = (i == 32'h52 || i == 32'h53) ? 8'hFF : (8'(i) ^ 8'hA5);
      rd_reg(8'(i), rd);
      chk($sformatf("rw %h", i), rd, {24'h000000, v});
    end
    // Unmapped neighbours read zero, writes leave nothing
    wr_reg(8'h5D, 32'h000000C3);
    rd_reg(8'h5D, rd);
    chk("unmapped 5D", rd, 32'h00000000);
    rd_reg(8'h46, rd);
    chk("unmapped 46", rd, 32'h00000000);
    chk("hresp okay", {31'h0, hresp}, 32'h00000000);
    // Window compare on analog input zero, both edges of the window
    wr_reg(8'h50, 32'h00000080);
    wr_reg(8'h58, 32'h00000020);
    for (int k = 0; k < 4; k++)
    begin
      case (k)
        0: meas[8] <= 8'h81;
        1: meas[8] <= 8'h80;
        2: meas[8] <= 8'h20;
        default: meas[8] <= 8'h1F;
      endcase
      settle();
      chk($sformatf("over8 case %0d", k), {31'h0, over[8]}, {31'h0, k == 0});
      chk($sformatf("under8 case %0d", k), {31'h0, under[8]}, {31'h0, k == 3});
    end
    // Own under status: analog inputs zero to four below their low limits
    rd_reg(8'h7D, rd);
    chk("under hi", rd, 32'h0000001F);
    // Clock enable low freezes the flags; -12V above its written high limit
    ce <= 1'b0;
    meas[0] <= 8'hF0;
    settle();
    chk("over0 frozen", {31'h0, over[0]}, 32'h00000000);
    ce <= 1'b1;
    settle();
    chk("over0 run", {31'h0, over[0]}, 32'h00000001);
    rd_reg(8'h7A, rd);
    chk("over lo", rd, 32'h00000001);
    // Shared low limit: signed in temperature mode, unsigned as analog input
    wr_reg(8'h49, 32'h00000030);
    meas[2] <= 8'hF0;
    settle();
    chk("mode temp", {31'h0, ch2_analog}, 32'h00000000);
    chk("under2 temp", {31'h0, under[2]}, 32'h00000001);
    wr_reg(8'h7E, 32'h00000001);
    settle();
    chk("mode analog", {31'h0, ch2_analog}, 32'h00000001);
    chk("under2 analog", {31'h0, under[2]}, 32'h00000000);
    rd_reg(8'h7E, rd);
    chk("cfg read", rd, 32'h00000001);
    rd_reg(8'h49, rd);
    chk("shared limit", rd, 32'h00000030);
    meas[2] <= 8'h2F;
    settle();
    chk("under2 low", {31'h0, under[2]}, 32'h00000001);
    // Reset in mid-run restores power-on values and mode
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("mode reset", {31'h0, ch2_analog}, 32'h00000000);
    rd_reg(8'h49, rd);
    chk("shared reset", rd, 32'h00000080);
    rd_reg(8'h50, rd);
    chk("high reset", rd, 32'h000000FF);
    rd_reg(8'h58, rd);
    chk("low reset", rd, 32'h00000000);
    final_report();
  end
endmodule
`default_nettype wire

// file: rtl/lmtb_ahb_slave.sv
/*
  AHB-Lite slave front end: turns single word transfers into
  register strobes. Assumes it is the only slave (hready = hreadyout).
*/
`timescale 1ns/1ps
`default_nettype none
module lmtb_ahb_slave (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // AHB-Lite
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Register side
  lmtb_reg_if.bus rb
);
  lmtb_pkg::lmtb_bus_state_e state;
  lmtb_pkg::lmtb_bus_state_e next_state;
  logic [7:0] idx_q;
  logic map_ok;
  logic accept;

  // Address phase taken when selected and bus ready
  assign accept = i_hsel && i_htrans[1] && i_hready;

  // Next transfer state
  always_comb
  begin
    next_state = state;
    case (state)
      lmtb_pkg::ST_RD_WAIT: next_state = lmtb_pkg::ST_RD_DONE;
      default:
      begin
        if (accept && i_hwrite)
          next_state = lmtb_pkg::ST_WR;
        else if (accept)
          next_state = lmtb_pkg::ST_RD_WAIT;
        else
          next_state = lmtb_pkg::ST_IDLE;
      end
    endcase
  end

  // State and latched address
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state <= lmtb_pkg::ST_IDLE;
      idx_q <= 8'h00;
      map_ok <= 1'b0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      if (accept)
      begin
        idx_q <= i_haddr[9:2];
        map_ok <= (i_haddr[31:10] == 22'h000000) && (i_haddr[1:0] == 2'h0)
          && (i_hsize <= lmtb_pkg::HSIZE_WORD);
      end
    end
  end

  // Read data captured in the wait cycle, zero when unmapped
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_hrdata <= 32'h00000000;
    else if (i_ce && state == lmtb_pkg::ST_RD_WAIT)
      o_hrdata <= {24'h000000, map_ok ? rb.rdata : 8'h00};
  end

  // Strobes and response
  assign rb.wr = (state == lmtb_pkg::ST_WR) && map_ok;
  assign rb.idx = idx_q;
  assign rb.wdata = i_hwdata[7:0];
  assign o_hreadyout = (state != lmtb_pkg::ST_RD_WAIT);
  assign o_hresp = 1'b0;
endmodule
`default_nettype wire

// file: rtl/lmtb_limit_cmp.sv
/*
  Window comparator for one channel against its high and low limit.
  Assumes value and limits share one encoding chosen by i_signed.
*/
`timescale 1ns/1ps
`default_nettype none
module lmtb_limit_cmp #(
  parameter bit HAS_HI = 1'b1,
  parameter bit HAS_LO = 1'b1
) (
  // Operands
  input wire logic [7:0] i_value,
  input wire logic [7:0] i_high,
  input wire logic [7:0] i_low,
  input wire logic i_signed,
  // Flags
  output logic o_over,
  output logic o_under
);
  // Signed or unsigned compare per mode
  always_comb
  begin
    if (i_signed)
    begin
      o_over = HAS_HI && ($signed(i_value) > $signed(i_high));
      o_under = HAS_LO && ($signed(i_value) < $signed(i_low));
    end
    else
    begin
      o_over = HAS_HI && (i_value > i_high);
      o_under = HAS_LO && (i_value < i_low);
    end
  end
endmodule
`default_nettype wire

// file: rtl/lmtb_pkg.sv
/*
  Shared constants for the limit threshold bank: register indices,
  reset values, read-only mask, channel map and bus state codes.
  Assumes an 8-bit register index placed on a 32-bit word bus.
*/
`default_nettype none
package lmtb_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned N_SLOT = 22;
  localparam int unsigned N_CH = 16;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_MINUS12V_HIGH_LIMIT = 8'h47;
  localparam logic [7:0] IDX_REMOTE_TEMP1_LOW_LIMIT = 8'h48;
  localparam logic [7:0] IDX_REMOTE_TEMP2_OR_ANALOG9_LOW_LIMIT = 8'h49;
  localparam logic [7:0] IDX_STANDBY_3V3_LOW_LIMIT = 8'h4A;
  localparam logic [7:0] IDX_MAIN_3V3_LOW_LIMIT = 8'h4B;
  localparam logic [7:0] IDX_PLUS5V_LOW_LIMIT = 8'h4C;
  localparam logic [7:0] IDX_CPU_CORE_V_LOW_LIMIT = 8'h4D;
  localparam logic [7:0] IDX_PLUS12V_LOW_LIMIT = 8'h4E;
  localparam logic [7:0] IDX_MINUS12V_LOW_LIMIT = 8'h4F;
  localparam logic [7:0] IDX_ANALOG_INPUT0_HIGH_LIMIT = 8'h50;
  localparam logic [7:0] IDX_ANALOG_INPUT1_HIGH_LIMIT = 8'h51;
  localparam logic [7:0] IDX_ANALOG_INPUT2_HIGH_LIMIT = 8'h52;
  localparam logic [7:0] IDX_ANALOG_INPUT3_HIGH_LIMIT = 8'h53;
  localparam logic [7:0] IDX_ANALOG_INPUT4_HIGH_LIMIT = 8'h54;
  localparam logic [7:0] IDX_ANALOG_INPUT5_HIGH_LIMIT = 8'h55;
  localparam logic [7:0] IDX_ANALOG_INPUT6_HIGH_LIMIT = 8'h56;
  localparam logic [7:0] IDX_ANALOG_INPUT7_HIGH_LIMIT = 8'h57;
  localparam logic [7:0] IDX_ANALOG_INPUT0_LOW_LIMIT = 8'h58;
  localparam logic [7:0] IDX_ANALOG_INPUT1_LOW_LIMIT = 8'h59;
  localparam logic [7:0] IDX_ANALOG_INPUT2_LOW_LIMIT = 8'h5A;
  localparam logic [7:0] IDX_ANALOG_INPUT3_LOW_LIMIT = 8'h5B;
  localparam logic [7:0] IDX_ANALOG_INPUT4_LOW_LIMIT = 8'h5C;
  localparam logic [7:0] IDX_OVER_LO = 8'h7A;
  localparam logic [7:0] IDX_OVER_HI = 8'h7B;
  localparam logic [7:0] IDX_UNDER_LO = 8'h7C;
  localparam logic [7:0] IDX_UNDER_HI = 8'h7D;
  localparam logic [7:0] IDX_CFG = 8'h7E;
  // ---------------------------------------------------------------
  // Reset values and access
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_HI = 8'hFF;
  localparam logic [7:0] RST_LO = 8'h00;
  localparam logic [7:0] RST_TEMP_LO = 8'h80;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] CFG_MASK = 8'h01;
  localparam int unsigned CFG_ANALOG_BIT = 0;
  localparam logic [N_SLOT-1:0][7:0] SLOT_RST = {{5{RST_LO}}, {8{RST_HI}},
    {6{RST_LO}}, {2{RST_TEMP_LO}}, RST_HI};
  localparam logic [N_SLOT-1:0] RO_MASK = 22'h001800;
  // ---------------------------------------------------------------
  // Channel map: slot of each channel's limits, 1F when absent
  // ---------------------------------------------------------------
  localparam logic [4:0] NO_SLOT = 5'h1F;
  localparam int unsigned CH_TEMP1 = 1;
  localparam int unsigned CH_SHARED = 2;
  localparam logic [N_CH-1:0][4:0] CH_HI_SLOT = {5'h10, 5'h0F, 5'h0E,
    5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h09, {7{NO_SLOT}}, 5'h00};
  localparam logic [N_CH-1:0][4:0] CH_LO_SLOT = {{3{NO_SLOT}}, 5'h15,
    5'h14, 5'h13, 5'h12, 5'h11, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03,
    5'h02, 5'h01, 5'h08};
  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WR = 4'h2,
    ST_RD_WAIT = 4'h4,
    ST_RD_DONE = 4'h8
  } lmtb_bus_state_e;
endpackage
`default_nettype wire

// file: rtl/lmtb_reg_if.sv
/*
  Register access channel between the bus slave and the bank.
  Assumes both ends share one clock; wr is a one-cycle strobe.
*/
`timescale 1ns/1ps
`default_nettype none
interface lmtb_reg_if;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus (output wr, output idx, output wdata, input rdata);
  modport bank (input wr, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// file: rtl/lmtb_top.sv
/*
  Limit threshold bank of a system hardware monitor: 8-bit limit
  registers behind AHB-Lite, per-channel window compare, alarm flags.
  Assumes measured values arrive on i_meas from logic on i_clk.
*/
// Function
// - Voltage and analog high-limit registers reset to all ones.
// - Voltage and analog low-limit registers reset to zero.
// - Both remote temperature low limits reset to 80 hex.
// - Shared low limit serves temp channel two or extra analog input.
// - Each limit is eight bits and belongs to exactly one channel.
`timescale 1ns/1ps
`default_nettype none
module lmtb_top (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Measured values
  input wire logic [lmtb_pkg::N_CH-1:0][7:0] i_meas,
  // Limit flags and mode
  output logic [lmtb_pkg::N_CH-1:0] o_over,
  output logic [lmtb_pkg::N_CH-1:0] o_under,
  output logic o_ch2_analog
);
  // ---------------------------------------------------------------
  // Storage and decode
  // ---------------------------------------------------------------
  lmtb_reg_if rb ();
  logic [lmtb_pkg::N_SLOT-1:0][7:0] limit;
  logic [7:0] cfg;
  logic [7:0] slot_full;
  logic [4:0] slot;
  logic slot_hit;
  logic wr_ok;
  logic [lmtb_pkg::N_CH-1:0] sign_mode;
  logic [lmtb_pkg::N_CH-1:0] next_over;
  logic [lmtb_pkg::N_CH-1:0] next_under;

  // ---------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------
  lmtb_ahb_slave u_ahb (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_hrdata(o_hrdata),
    .rb(rb.bus)
  );

  // Index to slot, limits occupy one contiguous index run
  assign slot_full = rb.idx - lmtb_pkg::IDX_MINUS12V_HIGH_LIMIT;
  assign slot = slot_full[4:0];
  assign slot_hit = (rb.idx >= lmtb_pkg::IDX_MINUS12V_HIGH_LIMIT)
    && (rb.idx <= lmtb_pkg::IDX_ANALOG_INPUT4_LOW_LIMIT);
  assign wr_ok = i_ce && rb.wr && slot_hit && !lmtb_pkg::RO_MASK[slot];

  // ---------------------------------------------------------------
  // Limit registers
  // ---------------------------------------------------------------
  // Power-on values per slot; one 8-bit word per limit
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      limit <= lmtb_pkg::SLOT_RST;
    else if (wr_ok)
      limit[slot] <= rb.wdata;
  end

  // Mode register: bit 0 selects the extra analog input
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      cfg <= lmtb_pkg::RST_CFG;
    else if (i_ce && rb.wr && rb.idx == lmtb_pkg::IDX_CFG)
      cfg <= rb.wdata & lmtb_pkg::CFG_MASK;
  end

  assign o_ch2_analog = cfg[lmtb_pkg::CFG_ANALOG_BIT];

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Limits by slot, own status and mode above; others read zero
  always_comb
  begin
    rb.rdata = 8'h00;
    if (slot_hit)
      rb.rdata = limit[slot];
    else
    begin
      case (rb.idx)
        lmtb_pkg::IDX_OVER_LO: rb.rdata = o_over[7:0];
        lmtb_pkg::IDX_OVER_HI: rb.rdata = o_over[15:8];
        lmtb_pkg::IDX_UNDER_LO: rb.rdata = o_under[7:0];
        lmtb_pkg::IDX_UNDER_HI: rb.rdata = o_under[15:8];
        lmtb_pkg::IDX_CFG: rb.rdata = cfg;
        default: rb.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Window compare
  // ---------------------------------------------------------------
  // Temperatures are two's complement; shared channel follows mode
  always_comb
  begin
    sign_mode = '0;
    sign_mode[lmtb_pkg::CH_TEMP1] = 1'b1;
    sign_mode[lmtb_pkg::CH_SHARED] = !o_ch2_analog;
  end

  // One comparator per channel, absent limits never trip
  for (genvar g = 0; g < lmtb_pkg::N_CH; g++)
  begin : g_ch
    localparam logic [4:0] HS = lmtb_pkg::CH_HI_SLOT[g];
    localparam logic [4:0] LS = lmtb_pkg::CH_LO_SLOT[g];
    logic [7:0] hi_v;
    logic [7:0] lo_v;
    if (HS != lmtb_pkg::NO_SLOT)
    begin : g_hi
      assign hi_v = limit[HS];
    end
    else
    begin : g_no_hi
      assign hi_v = lmtb_pkg::RST_HI;
    end
    if (LS != lmtb_pkg::NO_SLOT)
    begin : g_lo
      assign lo_v = limit[LS];
    end
    else
    begin : g_no_lo
      assign lo_v = lmtb_pkg::RST_LO;
    end
    lmtb_limit_cmp #(
      .HAS_HI(HS != lmtb_pkg::NO_SLOT),
      .HAS_LO(LS != lmtb_pkg::NO_SLOT)
    ) u_cmp (
      .i_value(i_meas[g]),
      .i_high(hi_v),
      .i_low(lo_v),
      .i_signed(sign_mode[g]),
      .o_over(next_over[g]),
      .o_under(next_under[g])
    );
  end

  // Registered flags, live (not sticky)
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_over <= '0;
      o_under <= '0;
    end
    else if (i_ce)
    begin
      o_over <= next_over;
      o_under <= next_under;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic hi_all_ones;
  logic lo_all_zero;

  // Reduce all high limits and all voltage low limits
  always_comb
  begin
    hi_all_ones = 1'b1;
    lo_all_zero = 1'b1;
    for (int c = 0; c < lmtb_pkg::N_CH; c++)
    begin
      if (lmtb_pkg::CH_HI_SLOT[c] != lmtb_pkg::NO_SLOT)
        hi_all_ones &= (limit[lmtb_pkg::CH_HI_SLOT[c]] == lmtb_pkg::RST_HI);
      if (lmtb_pkg::CH_LO_SLOT[c] != lmtb_pkg::NO_SLOT
          && c != lmtb_pkg::CH_TEMP1 && c != lmtb_pkg::CH_SHARED)
        lo_all_zero &= (limit[lmtb_pkg::CH_LO_SLOT[c]] == lmtb_pkg::RST_LO);
    end
  end

  // Reset drives the limits to their power-on values
  a_high_rst_ones:
    assert property (@(posedge i_clk) !i_rst_n |=> hi_all_ones)
    else $error("high limit not all ones after reset");

  a_low_rst_zero:
    assert property (@(posedge i_clk) !i_rst_n |=> lo_all_zero)
    else $error("voltage low limit not zero after reset");

  a_temp_low_rst:
    assert property (@(posedge i_clk) !i_rst_n |=>
      (limit[1] == lmtb_pkg::RST_TEMP_LO) && (limit[2] == lmtb_pkg::RST_TEMP_LO))
    else $error("temperature low limit not 80 after reset");

  // Writes land in the addressed slot, writes to other slots leave limit 0 alone; writes to read-only slots change nothing
  sequence s_limit_wr;
    wr_ok;
  endsequence

  a_write_stores:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_limit_wr |=> limit[$past(slot)] == $past(rb.wdata))
    else $error("limit write not stored");

  a_write_isolated:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (s_limit_wr and (slot != 5'h00)) |=> $stable(limit[0]))
    else $error("write disturbed another limit");

  a_ro_holds:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && rb.wr && slot_hit && lmtb_pkg::RO_MASK[slot])
      |=> $stable(limit))
    else $error("read-only limit changed");

  // Shared channel compare follows the configured function
  sequence s_shared_temp_low;
    i_ce && !o_ch2_analog && ($signed(i_meas[2]) < $signed(limit[2]));
  endsequence

  sequence s_shared_analog_ok;
    i_ce && o_ch2_analog && (i_meas[2] >= limit[2]);
  endsequence

  a_shared_temp:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_shared_temp_low |=> o_under[2])
    else $error("shared channel missed signed low limit");

  a_shared_analog:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_shared_analog_ok |=> !o_under[2])
    else $error("shared channel flagged in analog mode");

  // Out-of-range values flag, in-range values clear, one cycle later
  a_over_flag:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_meas[0] > limit[0]) |=> o_over[0])
    else $error("high limit crossing not flagged");

  a_under_clear:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_meas[8] >= limit[17]) |=> !o_under[8])
    else $error("low flag set with value in range");

  // Bus read returns the addressed limit after one wait cycle
  sequence s_rd_m12;
    i_ce && i_hsel && i_htrans == lmtb_pkg::HTRANS_NONSEQ && !i_hwrite
      && i_hready && i_haddr == 32'h0000011C;
  endsequence

  a_bus_read:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_rd_m12 ##1 i_ce |-> !o_hreadyout ##1
      (o_hreadyout && o_hrdata == {24'h000000, limit[0]}))
    else $error("bus read of limit wrong");
endmodule
`default_nettype wire
